// ---- include/range_type_pkg.sv ----
// Constants for the memory-type range lookup unit: register offsets, fields,
// reset values and memory type encodings.
// Assumes a 32-bit APB register bus and 4 KByte granule lookups.
package range_type_pkg;

  // Register byte offsets
  localparam logic [11:0] CAP_OFF      = 12'h000;
  localparam logic [11:0] DEF_TYPE_OFF = 12'h004;
  localparam logic [11:0] CTRL0_OFF    = 12'h008;
  localparam logic [11:0] CTRL4_OFF    = 12'h00C;
  localparam logic [11:0] PTB_OFF      = 12'h010;
  localparam logic [11:0] CHK_BASE_OFF = 12'h014;
  localparam logic [11:0] CHK_SIZE_OFF = 12'h018;
  localparam logic [11:0] STATUS_OFF   = 12'h01C;
  localparam logic [11:0] FIX_OFF      = 12'h100;
  localparam logic [11:0] VAR_OFF      = 12'h200;

  // Field positions
  localparam int CAP_FIX_BIT   = 8;
  localparam int CAP_COMB_BIT  = 10;
  localparam int CAP_SNOOP_BIT = 27;
  localparam int DEF_FIX_BIT   = 10;
  localparam int DEF_E_BIT     = 11;
  localparam int MASK_V_BIT    = 11;
  localparam int NOCACHE_BIT   = 30;
  localparam int NWT_BIT       = 29;
  localparam int PGLOB_BIT     = 7;
  localparam int ST_OK_BIT     = 0;
  localparam int ST_NOFILL_BIT = 1;

  // Writable bits of each register
  localparam logic [31:0] DEF_TYPE_WMASK = 32'h0000_0CFF;
  localparam logic [31:0] BASE_WMASK     = 32'hFFFF_F0FF;
  localparam logic [31:0] MASK_WMASK     = 32'hFFFF_F800;
  localparam logic [31:0] CTRL0_WMASK    = 32'h6000_0000;
  localparam logic [31:0] CTRL4_WMASK    = 32'h0000_0080;
  localparam logic [31:0] PTB_WMASK      = 32'hFFFF_F000;

  // Reset values
  localparam logic [31:0] DEF_TYPE_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL0_RST    = 32'h6000_0000;
  localparam logic [31:0] ZERO_RST     = 32'h0000_0000;

  // Fixed range layout: 8 x 64K, 16 x 16K, 64 x 4K entries
  localparam int NUM_FIX       = 88;
  localparam int NUM_FIX_WORDS = 22;
  localparam int FIX16_FIRST   = 8;
  localparam int FIX4_FIRST    = 24;

  // Memory type encodings
  localparam logic [7:0] UNCACHEABLE_TYPE     = 8'h00;
  localparam logic [7:0] WRITE_COMBINING_TYPE = 8'h01;
  localparam logic [7:0] WRITE_THROUGH_TYPE   = 8'h04;
  localparam logic [7:0] WRITE_PROTECTED_TYPE = 8'h05;
  localparam logic [7:0] WRITE_BACK_TYPE      = 8'h06;

endpackage

// ---- src/range_type_resolve.sv ----
// Combinational resolver: turns a 4 KByte granule number into a memory type.
// Assumes the register contents are stable flops from the enclosing unit.
`timescale 1ns/10ps
module range_type_resolve
  import range_type_pkg::*;
#(
  parameter int NUM_VAR = 8
) (
  // Lookup
  input  wire logic [19:0]                    granule,
  output logic      [7:0]                     type_out,
  // Configuration
  input  wire logic                           typing_enable,
  input  wire logic                           fixed_enable,
  input  wire logic                           fixed_capable,
  input  wire logic [7:0]                     variable_pair_count,
  input  wire logic [7:0]                     default_type,
  input  wire logic [NUM_FIX-1:0][7:0]        fixed_types,
  input  wire logic [NUM_VAR-1:0][19:0]       pair_base,
  input  wire logic [NUM_VAR-1:0][7:0]        pair_type,
  input  wire logic [NUM_VAR-1:0][19:0]       pair_mask,
  input  wire logic [NUM_VAR-1:0]             pair_valid
);

  logic [NUM_VAR-1:0] pair_hit;
  logic [6:0]         fix_index;
  logic               in_fixed;

  // One comparator per pair; uncounted or invalid pairs never hit
  generate
    for (genvar i = 0; i < NUM_VAR; i++) begin : g_pair
      assign pair_hit[i] = pair_valid[i] && (8'(i) < variable_pair_count) &&
                           ((granule & pair_mask[i]) == (pair_base[i] & pair_mask[i]));
    end
  endgenerate

  // Fixed region index from the granule below 1 MByte
  always_comb begin
    in_fixed  = (granule[19:8] == 12'h000);
    if (granule[7] == 1'b0) begin
      fix_index = {4'h0, granule[6:4]};
    end else if (granule[6] == 1'b0) begin
      fix_index = 7'(FIX16_FIRST) + {3'h0, granule[5:2]};
    end else begin
      fix_index = 7'(FIX4_FIRST) + {1'b0, granule[5:0]};
    end
  end

  // Priority: disabled, fixed, variable, default
  always_comb begin
    logic       any_hit;
    logic       any_unc;
    logic       any_thr;
    logic       any_bck;
    logic [7:0] first_type;
    any_hit    = 1'b0;
    any_unc    = 1'b0;
    any_thr    = 1'b0;
    any_bck    = 1'b0;
    first_type = UNCACHEABLE_TYPE;
    for (int i = NUM_VAR - 1; i >= 0; i--) begin
      if (pair_hit[i]) begin
        any_hit    = 1'b1;
        first_type = pair_type[i];
        any_unc    = any_unc | (pair_type[i] == UNCACHEABLE_TYPE);
        any_thr    = any_thr | (pair_type[i] == WRITE_THROUGH_TYPE);
        any_bck    = any_bck | (pair_type[i] == WRITE_BACK_TYPE);
      end
    end
    if (!typing_enable) begin
      type_out = UNCACHEABLE_TYPE;
    end else if (fixed_capable && fixed_enable && in_fixed) begin
      type_out = fixed_types[fix_index];
    end else if (any_unc) begin
      type_out = UNCACHEABLE_TYPE;
    end else if (any_thr && any_bck) begin
      type_out = WRITE_THROUGH_TYPE; // Safer of the two write policies
    end else if (any_hit) begin
      type_out = first_type;
    end else begin
      type_out = default_type;
    end
  end

endmodule

// ---- src/range_type_unit.sv ----
// Memory-type range unit: APB register file, cache mode and TLB flush
// controls, range request checker and the lookup port.
// Assumes APB master in pclk domain; lookup requests synchronous to pclk.
`timescale 1ns/10ps
module range_type_unit
  import range_type_pkg::*;
#(
  parameter int          NUM_VAR     = 8,
  parameter logic        FIX_CAPABLE = 1'b1,
  parameter logic        CMB_CAPABLE = 1'b1,
  parameter logic        SELF_SNOOP  = 1'b0
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Lookup port
  input  wire logic        lookup_req,
  input  wire logic [19:0] lookup_granule,
  output logic      [7:0]  lookup_type,
  output logic             lookup_valid,
  // Cache and TLB controls
  output logic             cache_no_fill,
  output logic             cache_disabled,
  output logic             tlb_flush
);

  // Pair index wide enough for the pair array only, so no index bit is dropped
  localparam int PAIR_IW = (NUM_VAR > 1) ? $clog2(NUM_VAR) : 1;

  logic [31:0]                     default_type_register;
  logic [31:0]                     control_register_zero;
  logic [31:0]                     control_register_four;
  logic [31:0]                     page_table_base_register;
  logic [31:0]                     check_base;
  logic [31:0]                     check_size;
  logic [NUM_FIX_WORDS-1:0][31:0]  fixed_range_register;
  logic [NUM_VAR-1:0][31:0]        variable_base_register;
  logic [NUM_VAR-1:0][31:0]        variable_mask_register;
  logic [31:0]                     range_capability_register;
  logic [31:0]                     status_word;
  logic [32:0]                     check_end;
  logic                            check_ok;
  logic                            setup;
  logic                            wr_en;
  logic                            is_fix;
  logic                            is_var;
  logic                            is_mapped;
  logic [11:0]                     fix_rel;
  logic [11:0]                     var_rel;
  logic [4:0]                      fix_word;
  logic [7:0]                      var_pair;
  logic                            var_is_mask;
  logic [PAIR_IW-1:0]              pair_idx;
  logic [31:0]                     next_prdata;
  logic [NUM_VAR-1:0][19:0]        pair_base;
  logic [NUM_VAR-1:0][7:0]         pair_type;
  logic [NUM_VAR-1:0][19:0]        pair_mask;
  logic [NUM_VAR-1:0]              pair_valid;

  // Read-only capability word
  assign range_capability_register = {4'h0, SELF_SNOOP, 16'h0000, CMB_CAPABLE, 1'b0, FIX_CAPABLE,
                                      8'(NUM_VAR)};

  // Address decode; the slave always answers in the first access cycle
  assign setup       = psel && !penable;
  assign wr_en       = psel && penable && pwrite;
  assign fix_rel     = paddr - FIX_OFF;
  assign var_rel     = paddr - VAR_OFF;
  assign fix_word    = fix_rel[6:2];
  assign var_pair    = var_rel[10:3];
  assign var_is_mask = var_rel[2];
  assign pair_idx    = var_pair[PAIR_IW-1:0];
  assign is_fix      = (paddr >= FIX_OFF) && (fix_rel < 12'(NUM_FIX_WORDS * 4)) && (paddr[1:0] == 2'b00);
  assign is_var      = (paddr >= VAR_OFF) && (var_rel < 12'(NUM_VAR * 8)) && (paddr[1:0] == 2'b00);
  assign pready      = 1'b1;

  // Range request check: aligned, nonzero size, end inside 4 GByte space
  assign check_end = {1'b0, check_base} + {1'b0, check_size};
  assign check_ok  = (check_base[11:0] == 12'h000) && (check_size[11:0] == 12'h000) &&
                     (check_size != 32'h0000_0000) &&
                     (!check_end[32] || (check_end[31:0] == 32'h0000_0000));

  // No-fill mode: caches disabled while write-through bit is clear
  assign status_word = {30'h0, cache_no_fill, check_ok};
  assign cache_disabled = control_register_zero[NOCACHE_BIT];
  assign cache_no_fill  = control_register_zero[NOCACHE_BIT] && !control_register_zero[NWT_BIT];

  // Read mux, sampled in the setup cycle so read data comes from a flop
  always_comb begin
    next_prdata = 32'h0000_0000;
    is_mapped   = 1'b1;
    if (is_fix) begin
      next_prdata = fixed_range_register[fix_word];
    end else if (is_var) begin
      next_prdata = var_is_mask ? variable_mask_register[pair_idx]
                                : variable_base_register[pair_idx];
    end else begin
      case (paddr)
        CAP_OFF:      next_prdata = range_capability_register;
        DEF_TYPE_OFF: next_prdata = default_type_register;
        CTRL0_OFF:    next_prdata = control_register_zero;
        CTRL4_OFF:    next_prdata = control_register_four;
        PTB_OFF:      next_prdata = page_table_base_register;
        CHK_BASE_OFF: next_prdata = check_base;
        CHK_SIZE_OFF: next_prdata = check_size;
        STATUS_OFF:   next_prdata = status_word;
        default:      is_mapped = 1'b0;
      endcase
    end
  end

  // Read data and error answer registered at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= ZERO_RST;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? ZERO_RST : next_prdata;
      pslverr <= !is_mapped;
    end
  end

  // Default type register; global enable cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      default_type_register <= DEF_TYPE_RST;
    end else if (wr_en && paddr == DEF_TYPE_OFF) begin
      default_type_register <= pwdata & DEF_TYPE_WMASK;
    end
  end

  // Fixed range storage, four type fields per word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_range_register <= '0;
    end else if (wr_en && is_fix) begin
      fixed_range_register[fix_word] <= pwdata;
    end
  end

  // Variable pairs; reset clears every valid bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      variable_base_register <= '0;
      variable_mask_register <= '0;
    end else if (wr_en && is_var) begin
      if (var_is_mask) begin
        variable_mask_register[pair_idx] <= pwdata & MASK_WMASK;
      end else begin
        variable_base_register[pair_idx] <= pwdata & BASE_WMASK;
      end
    end
  end

  // Cache control word; caches start disabled after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_register_zero <= CTRL0_RST;
    end else if (wr_en && paddr == CTRL0_OFF) begin
      control_register_zero <= pwdata & CTRL0_WMASK;
    end
  end

  // Page-global enable and page table base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_register_four    <= ZERO_RST;
      page_table_base_register <= ZERO_RST;
    end else begin
      if (wr_en && paddr == CTRL4_OFF) begin
        control_register_four <= pwdata & CTRL4_WMASK;
      end
      if (wr_en && paddr == PTB_OFF) begin
        page_table_base_register <= pwdata & PTB_WMASK;
      end
    end
  end

  // TLB flush pulse: page-global cleared from set, or base reloaded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tlb_flush <= 1'b0;
    end else begin
      tlb_flush <= (wr_en && paddr == CTRL4_OFF && control_register_four[PGLOB_BIT] && !pwdata[PGLOB_BIT]) ||
                   (wr_en && paddr == PTB_OFF);
    end
  end

  // Range request operands for the alignment checker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_base <= ZERO_RST;
      check_size <= ZERO_RST;
    end else begin
      if (wr_en && paddr == CHK_BASE_OFF) begin
        check_base <= pwdata;
      end
      if (wr_en && paddr == CHK_SIZE_OFF) begin
        check_size <= pwdata;
      end
    end
  end

  // Unpack pair fields for the resolver
  generate
    for (genvar i = 0; i < NUM_VAR; i++) begin : g_unpack
      assign pair_base[i]  = variable_base_register[i][31:12];
      assign pair_type[i]  = variable_base_register[i][7:0];
      assign pair_mask[i]  = variable_mask_register[i][31:12];
      assign pair_valid[i] = variable_mask_register[i][MASK_V_BIT];
    end
  endgenerate

  // Answer in the request cycle from current register contents
  assign lookup_valid = lookup_req;

  range_type_resolve #(
    .NUM_VAR (NUM_VAR)
  ) u_resolve (
    .granule             (lookup_granule),
    .type_out            (lookup_type),
    .typing_enable       (default_type_register[DEF_E_BIT]),
    .fixed_enable        (default_type_register[DEF_FIX_BIT]),
    .fixed_capable       (FIX_CAPABLE),
    .variable_pair_count (8'(NUM_VAR)),
    .default_type        (default_type_register[7:0]),
    .fixed_types         (fixed_range_register),
    .pair_base           (pair_base),
    .pair_type           (pair_type),
    .pair_mask           (pair_mask),
    .pair_valid          (pair_valid)
  );

endmodule

// ---- tb/range_type_unit_chk.sv ----
// Checker for the range type unit: APB answers, flush pulses, lookup port.
// Assumes it is bound to range_type_unit and sees only its ports.
`timescale 1ns/10ps
module range_type_unit_chk
  import range_type_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Lookup and cache controls
  input wire logic        lookup_req,
  input wire logic [7:0]  lookup_type,
  input wire logic        lookup_valid,
  input wire logic        cache_no_fill,
  input wire logic        cache_disabled,
  input wire logic        tlb_flush
);
  logic wr;
  logic fl_wr;
  logic en;
  // Write strobes at the access edge
  assign wr = psel && penable && pwrite && pready;
  assign fl_wr = wr && (paddr == CTRL4_OFF || paddr == PTB_OFF);
  // Shadow of the global enable, since the checker cannot see inside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      en <= 1'b0;
    else if (wr && paddr == DEF_TYPE_OFF)
      en <= pwdata[DEF_E_BIT];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_off_uncached: assert property (lookup_req && !en |-> lookup_type == UNCACHEABLE_TYPE)
    else $error("lookup type not uncacheable while typing off");
  chk_valid_req: assert property (lookup_valid == lookup_req)
    else $error("lookup valid differs from request");
  chk_nofill_mode: assert property (wr && paddr == CTRL0_OFF |=>
    cache_no_fill == ($past(pwdata[NOCACHE_BIT]) && !$past(pwdata[NWT_BIT])))
    else $error("no-fill mode wrong after control write");
  chk_nocache_write: assert property (wr && paddr == CTRL0_OFF |=>
    cache_disabled == $past(pwdata[NOCACHE_BIT]))
    else $error("cache disable wrong after control write");
  chk_ptb_flush: assert property (wr && paddr == PTB_OFF |=> tlb_flush)
    else $error("no flush after base reload");
  chk_flush_pulse: assert property (tlb_flush |=> !tlb_flush)
    else $error("flush longer than one cycle");
  chk_flush_cause: assert property (tlb_flush |-> $past(fl_wr))
    else $error("flush without a flushing write");
  chk_bad_addr: assert property (psel && penable && (paddr[1:0] != 2'h0 || (paddr > STATUS_OFF && paddr < FIX_OFF))
    |-> pslverr && pready)
    else $error("bad address not refused");
endmodule

bind range_type_unit range_type_unit_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .lookup_req(lookup_req),
  .lookup_type(lookup_type), .lookup_valid(lookup_valid), .cache_no_fill(cache_no_fill),
  .cache_disabled(cache_disabled), .tlb_flush(tlb_flush));

// ---- tb/lookup_requester.sv ----
// Model of the core's access path: raises lookups and registers each requested granule.
// Assumes bench commands change just after a rising edge.
`timescale 1ns/10ps
module lookup_requester (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Commands from the bench
  input  wire logic        want,
  input  wire logic [19:0] want_granule,
  // Lookup port of the unit
  output logic             lookup_req,
  output logic      [19:0] lookup_granule
);
  // Idle granule toggles so a stale address never passes for a request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lookup_req     <= 1'b0;
      lookup_granule <= 20'h00000;
    end else begin
      lookup_req     <= want;
      lookup_granule <= want ? want_granule : ~lookup_granule;
    end
  end
endmodule

// ---- tb/tb_range_type_unit.sv ----
// Bench for the range type unit: range update sequence and random lookups.
// Assumes the checker is bound in and the requester drives the lookup port.
`timescale 1ns/10ps
module tb_range_type_unit
  import range_type_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, want = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, rb, rs;
  logic        pready, pslverr, lookup_req, lookup_valid, cache_no_fill, cache_disabled, tlb_flush, e, en, fix_on;
  logic [19:0] lookup_granule, g, m, want_g = 20'h0;
  logic [7:0]  lookup_type, dt, fx [NUM_FIX], vt [8];
  logic [19:0] vb [8], vm [8];
  logic        vv [8];
  logic [7:0]  tset [5] = '{UNCACHEABLE_TYPE, WRITE_COMBINING_TYPE, WRITE_THROUGH_TYPE, WRITE_PROTECTED_TYPE,
                            WRITE_BACK_TYPE};
  logic [19:0] eg [10] = '{20'h7F, 20'h80, 20'hBF, 20'hC0, 20'hFF, 20'h100, 20'h40000, 20'h40005, 20'h40050,
                           20'h50000};
  logic [31:0] cb [5] = '{32'h1000, 32'h1800, 32'h2000, 32'hFFFF_F000, 32'hFFFF_F000};
  logic [31:0] cs [5] = '{32'h1000, 32'h1000, 32'h0, 32'h1000, 32'h2000};
  int          err_total = 0, checks_done = 0, k;
  // Clock
  always #5 pclk = ~pclk;
  range_type_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lookup_req(lookup_req),
    .lookup_granule(lookup_granule), .lookup_type(lookup_type), .lookup_valid(lookup_valid),
    .cache_no_fill(cache_no_fill), .cache_disabled(cache_disabled), .tlb_flush(tlb_flush));
  lookup_requester core (.pclk(pclk), .presetn(presetn), .want(want), .want_granule(want_g),
    .lookup_req(lookup_req), .lookup_granule(lookup_granule));
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_total++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_def(input logic ge, input logic f, input logic [7:0] t);
    apb(1'b1, DEF_TYPE_OFF, {20'h0, ge, f, 2'b00, t});
    en = ge;
    fix_on = f;
    dt = t;
  endtask
  task automatic set_pair(input int i, input logic [19:0] b, input logic [19:0] mk, input logic [7:0] t,
                          input logic v);
    apb(1'b1, VAR_OFF + 12'(8 * i), {b, 4'h0, t});
    apb(1'b1, VAR_OFF + 12'(8 * i + 4), {mk, v, 11'h0});
    vb[i] = b;
    vm[i] = mk;
    vt[i] = t;
    vv[i] = v;
  endtask
  // Expected type: enable, fixed map below 1 MByte, then pairs, then default
  function automatic logic [7:0] exp_type(input logic [19:0] gr);
    logic [7:0] t;
    logic       hit;
    logic       unc, thr, bck;
    if (!en)
      return UNCACHEABLE_TYPE;
    if (fix_on && gr < 20'h100) begin
      if (gr < 20'h80)
        return fx[gr >> 4];
      if (gr < 20'hC0)
        return fx[FIX16_FIRST + ((gr - 20'h80) >> 2)];
      return fx[FIX4_FIRST + (gr - 20'hC0)];
    end
    t = dt;
    hit = 1'b0;
    unc = 1'b0;
    thr = 1'b0;
    bck = 1'b0;
    // Any uncacheable match wins, then through over back, else lowest pair
    for (int i = 0; i < 8; i++) begin
      if (vv[i] && (gr & vm[i]) == (vb[i] & vm[i])) begin
        if (!hit)
          t = vt[i];
        hit = 1'b1;
        unc = unc | (vt[i] == UNCACHEABLE_TYPE);
        thr = thr | (vt[i] == WRITE_THROUGH_TYPE);
        bck = bck | (vt[i] == WRITE_BACK_TYPE);
      end
    end
    if (unc)
      return UNCACHEABLE_TYPE;
    if (thr && bck)
      return WRITE_THROUGH_TYPE;
    return t;
  endfunction
  // Range request is good when aligned, nonzero and ending at or below 4 GByte
  function automatic logic exp_ok(input logic [31:0] b, input logic [31:0] s);
    logic [32:0] sum;
    sum = {1'b0, b} + {1'b0, s};
    return b[11:0] == 12'h000 && s[11:0] == 12'h000 && s != 32'h0000_0000 && sum <= 33'h1_0000_0000;
  endfunction
  task automatic look(input logic [19:0] gr);
    @(posedge pclk);
    want <= 1'b1;
    want_g <= gr;
    #1;
    chk("lookup_idle", 32'h0, 32'(lookup_valid));
    @(posedge pclk);
    want <= 1'b0;
    #1;
    chk("lookup_valid", 32'h1, 32'(lookup_valid));
    chk("lookup_type", 32'(exp_type(gr)), 32'(lookup_type));
  endtask
  task automatic edges;
    foreach (eg[i])
      look(eg[i]);
  endtask
  // Reset values and the disabled state after every reset
  task automatic reset_check;
    en = 1'b0;
    fix_on = 1'b0;
    dt = 8'h00;
    foreach (vv[i])
      vv[i] = 1'b0;
    foreach (fx[i])
      fx[i] = 8'h00;
    chk("cache_disabled", 32'h1, 32'(cache_disabled));
    chk("cache_no_fill", 32'h0, 32'(cache_no_fill));
    apb(1'b0, DEF_TYPE_OFF, 32'h0);
    chk("def_type", DEF_TYPE_RST, q);
    apb(1'b0, VAR_OFF + 12'h03C, 32'h0);
    chk("mask7", ZERO_RST, q);
    apb(1'b0, CTRL0_OFF, 32'h0);
    chk("ctrl0", CTRL0_RST, q);
    apb(1'b0, CAP_OFF, 32'h0);
    chk("cap", (32'h1 << CAP_FIX_BIT) | (32'h1 << CAP_COMB_BIT) | 32'h8, q);
    look(20'(32'($urandom)));
  endtask
  initial begin
    void'($urandom(32'h2554));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    reset_check();
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", 32'h1, 32'(e));
    apb(1'b1, 12'h006, 32'hFFFF_FFFF);
    chk("misaligned_err", 32'h1, 32'(e));
    // Update sequence: no-fill, flush, typing off, load ranges
    apb(1'b1, CTRL0_OFF, 32'h4000_0000);
    #1;
    chk("no_fill", 32'h1, 32'(cache_no_fill));
    apb(1'b1, CTRL4_OFF, 32'h80);
    apb(1'b1, CTRL4_OFF, 32'h0);
    #1;
    chk("flush_pge", 32'h1, 32'(tlb_flush));
    apb(1'b1, PTB_OFF, 32'h0001_2000);
    #1;
    chk("flush_ptb", 32'h1, 32'(tlb_flush));
    set_def(1'b0, 1'b0, 8'h00);
    for (int w = 0; w < NUM_FIX_WORDS; w++) begin
      for (int b = 0; b < 4; b++)
        fx[4 * w + b] = tset[$urandom_range(4)];
      apb(1'b1, FIX_OFF + 12'(4 * w), {fx[4 * w + 3], fx[4 * w + 2], fx[4 * w + 1], fx[4 * w]});
    end
    for (int i = 0; i < 4; i++) begin
      m = 20'hFFFFF << $urandom_range(6);
      set_pair(i, 20'($urandom) & m, m, tset[$urandom_range(4)], 1'($urandom_range(3) != 0));
    end
    // Overlaps: uncacheable wins, write-through beats write-back; pair 4 not valid
    set_pair(4, 20'h50000, 20'hFFF00, UNCACHEABLE_TYPE, 1'b0);
    set_pair(5, 20'h40000, 20'hFFFFF, UNCACHEABLE_TYPE, 1'b1);
    set_pair(6, 20'h40000, 20'hFFF00, WRITE_BACK_TYPE, 1'b1);
    set_pair(7, 20'h40000, 20'hFFFF0, WRITE_THROUGH_TYPE, 1'b1);
    set_def(1'b1, 1'b1, WRITE_BACK_TYPE);
    apb(1'b1, PTB_OFF, 32'h0001_2000);
    edges();
    for (int n = 0; n < 300; n++) begin
      k = $urandom_range(7);
      case ($urandom_range(2))
        0: g = 20'($urandom_range(255));
        1: g = vb[k] | (20'($urandom) & ~vm[k]);
        default: g = 20'($urandom);
      endcase
      look(g);
    end
    set_def(1'b1, 1'b0, WRITE_COMBINING_TYPE);
    edges();
    set_pair(5, 20'h40000, 20'hFFFFF, UNCACHEABLE_TYPE, 1'b0);
    edges();
    set_def(1'b0, 1'b1, WRITE_BACK_TYPE);
    edges();
    // Range request checks, table then random
    for (int i = 0; i < 25; i++) begin
      rb = (i < 5) ? cb[i] : $urandom & 32'hFFFF_F800;
      rs = (i < 5) ? cs[i] : 32'($urandom_range(3)) << 12;
      apb(1'b1, CHK_BASE_OFF, rb);
      apb(1'b1, CHK_SIZE_OFF, rs);
      apb(1'b0, STATUS_OFF, 32'h0);
      chk("range_ok", 32'(exp_ok(rb, rs)), 32'(q[ST_OK_BIT]));
      chk("status_no_fill", 32'h1, 32'(q[ST_NOFILL_BIT]));
    end
    apb(1'b1, CTRL0_OFF, 32'h0);
    #1;
    chk("cache_normal", 32'h0, {30'h0, cache_disabled, cache_no_fill});
    apb(1'b1, CTRL4_OFF, 32'h80);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reset_check();
    summarize();
  end
endmodule
